/* File: logic/afc_cfg.svh */
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH

// Register byte offsets
`define AFC_OFF_CMP_CTRL 8'h00
`define AFC_OFF_OC_MODE 8'h04
`define AFC_OFF_OC_DAC 8'h08
`define AFC_OFF_OC_CAL 8'h0C
`define AFC_OFF_PH1_CTRL 8'h10
`define AFC_OFF_PH2_CTRL 8'h14
`define AFC_OFF_PIN_FN 8'h18
`define AFC_OFF_IRQ_STAT 8'h1C

// Reset values
`define AFC_RST_CMP_CTRL 8'hF0
`define AFC_RST_OC_MODE 8'h00
`define AFC_RST_OC_DAC 8'h00
`define AFC_RST_OC_CAL 8'h10
`define AFC_RST_PH_CTRL 8'h00
`define AFC_RST_PIN_FN 8'h00

// Writable bit masks
`define AFC_MASK_CMP_CTRL 8'hFF
`define AFC_MASK_OC_MODE 8'hC7
`define AFC_MASK_OC_CAL 8'h7F
`define AFC_MASK_PH_CTRL 8'h80
`define AFC_MASK_PIN_FN 8'h03

// Field positions
`define AFC_HYST_MSB 7
`define AFC_HYST_LSB 4
`define AFC_ON_MSB 3
`define AFC_ON_LSB 0
`define AFC_EDGE_MSB 7
`define AFC_EDGE_LSB 6
`define AFC_GAIN_MSB 2
`define AFC_GAIN_LSB 0
`define AFC_CALON_BIT 6
`define AFC_CALMODE_BIT 5
`define AFC_TRIM_MSB 4
`define AFC_TRIM_LSB 0
`define AFC_PHON_BIT 7
`define AFC_PINFN_MSB 1
`define AFC_PINFN_LSB 0
`define AFC_IRQ_BIT 0

// Shared pin function code that joins the negative inputs
`define AFC_PINFN_JOIN 2'h2

`endif

/* File: logic/afc_pkg.sv */
package afc_pkg;

    typedef enum logic [1:0]
    {
        AFC_EDGE_OFF = 2'h0,
        AFC_EDGE_RISE = 2'h1,
        AFC_EDGE_FALL = 2'h2,
        AFC_EDGE_BOTH = 2'h3
    } afc_edge_t;

    typedef struct packed
    {
        logic [3:0] hysteresis_en;
        logic [3:0] on;
    } afc_cmp_ctrl_t;

    typedef struct packed
    {
        logic amp_en;
        logic [2:0] overcurrent_amp_gain;
        logic offset_cal_on;
        logic cal_mode_sel;
        logic [4:0] offset_trim;
    } afc_oc_amp_t;

    typedef struct packed
    {
        logic phase_amp1_on;
        logic phase_amp2_on;
    } afc_phase_amp_t;

endpackage

/* File: logic/afc_regs.sv */
// Functional notes
// R1 - Comparator control bits 7..4 enable hysteresis per comparator, reset to one.
// R2 - Comparator control bits 3..0 switch comparators on, reset to zero.
// R3 - An enabled comparator disconnects pull-high resistors on its input pins.
// R4 - Software should clear unused comparator enables, also before sleep or idle.
// R5 - Edge field bits 7..6: off, rising, falling, both; off disables comparator 0, DAC.
// R6 - Gain field bits 2..0: off, 5, 10, 20, 1; codes 100..110 undefined.
// R7 - DAC register shows an 8-bit read-only reference value, reset zero.
// R8 - Calibration bit 6 turns amplifier offset calibration on, reset zero.
// R9 - Calibration bit 5 selects calibration mode when one, reset zero.
// R10 - Five-bit offset trim in bits 4..0, centre code 10000 at reset.
// R11 - First phase control bit 7 switches the first phase amplifier, reset zero.
// R12 - Second phase control bit 7 switches the second phase amplifier, reset zero.
// R13 - Unimplemented bits ignore writes and read as zero.
// R14 - Two over-current sources, limit and comparator 0, both can shut the drive.
// R15 - Pin function code 10 joins negative inputs of comparators 1..3 to common pin.
// R16 - Comparator 0 output synchronised; selected edge sets its request flag.
// R17 - Control fields drive analog macros statically, updated after a write.
`timescale 1ns/1ns
`include "afc_cfg.svh"
module afc_regs
    import afc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_zero_out,
    input wire logic [7:0] dac_code,
    input wire logic adc_limit_irq,
    output afc_cmp_ctrl_t cmp_ctrl,
    output logic [3:0] pullup_disconnect,
    output logic cmp_zero_active,
    output logic dac_on,
    output afc_oc_amp_t oc_amp,
    output afc_phase_amp_t phase_amp,
    output logic common_negative_join,
    output logic overcurrent_cmp_irq,
    output logic motor_shutdown_req
);
    logic [7:0] cmp_r;
    logic [7:0] cmp_nxt;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic [7:0] dac_r;
    logic [7:0] dac_nxt;
    logic [7:0] cal_r;
    logic [7:0] cal_nxt;
    logic [7:0] ph1_r;
    logic [7:0] ph1_nxt;
    logic [7:0] ph2_r;
    logic [7:0] ph2_nxt;
    logic [7:0] pin_r;
    logic [7:0] pin_nxt;
    logic irq_r;
    logic irq_nxt;
    logic c0_d_r;
    logic c0_d_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic c0_sync;
    logic setup;
    logic access;
    logic mapped;
    logic wr_en;
    logic irq_clr;
    logic rise;
    logic fall;
    logic edge_hit;
    afc_edge_t edge_sel;
    logic [2:0] gain;

    // Comparator 0 output crosses into the system clock
    afc_sync2 #(.W(1)) u_c0_sync
    (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(cmp_zero_out),
        .sync_out(c0_sync) // R16
    );

    // Bus decode
    always_comb
    begin
        setup = psel & ~penable;
        access = psel & penable;
        case (paddr)
            `AFC_OFF_CMP_CTRL, `AFC_OFF_OC_MODE, `AFC_OFF_OC_DAC, `AFC_OFF_OC_CAL,
            `AFC_OFF_PH1_CTRL, `AFC_OFF_PH2_CTRL, `AFC_OFF_PIN_FN, `AFC_OFF_IRQ_STAT:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
        wr_en = access & pwrite & mapped;
    end

    assign pready = access;
    assign pslverr = access & ~mapped;

    // Comparator 0 edge detection
    always_comb
    begin
        edge_sel = afc_edge_t'(mode_r[`AFC_EDGE_MSB:`AFC_EDGE_LSB]);
        rise = c0_sync & ~c0_d_r;
        fall = ~c0_sync & c0_d_r;
        case (edge_sel)
            AFC_EDGE_RISE: edge_hit = rise; // R5 R16
            AFC_EDGE_FALL: edge_hit = fall; // R5 R16
            AFC_EDGE_BOTH: edge_hit = rise | fall; // R5 R16
            default: edge_hit = 1'b0; // R16
        endcase
        irq_clr = wr_en && (paddr == `AFC_OFF_IRQ_STAT) && pwdata[`AFC_IRQ_BIT];
    end

    // Next register values
    always_comb
    begin
        cmp_nxt = cmp_r;
        mode_nxt = mode_r;
        cal_nxt = cal_r;
        ph1_nxt = ph1_r;
        ph2_nxt = ph2_r;
        pin_nxt = pin_r;
        if (wr_en)
        begin
            case (paddr)
                `AFC_OFF_CMP_CTRL: cmp_nxt = pwdata[7:0] & `AFC_MASK_CMP_CTRL; // R1 R2
                `AFC_OFF_OC_MODE: mode_nxt = pwdata[7:0] & `AFC_MASK_OC_MODE; // R5 R6 R13
                `AFC_OFF_OC_CAL: cal_nxt = pwdata[7:0] & `AFC_MASK_OC_CAL; // R8 R9 R10 R13
                `AFC_OFF_PH1_CTRL: ph1_nxt = pwdata[7:0] & `AFC_MASK_PH_CTRL; // R11 R13
                `AFC_OFF_PH2_CTRL: ph2_nxt = pwdata[7:0] & `AFC_MASK_PH_CTRL; // R12 R13
                `AFC_OFF_PIN_FN: pin_nxt = pwdata[7:0] & `AFC_MASK_PIN_FN; // R13
                default: cmp_nxt = cmp_r;
            endcase
        end
        dac_nxt = dac_code; // R7
        c0_d_nxt = c0_sync;
        irq_nxt = (irq_r & ~irq_clr) | edge_hit; // R16
    end

    // Read data captured in the setup cycle
    always_comb
    begin
        prdata_nxt = prdata_r;
        if (setup && !pwrite)
        begin
            case (paddr)
                `AFC_OFF_CMP_CTRL: prdata_nxt = {24'h000000, cmp_r};
                `AFC_OFF_OC_MODE: prdata_nxt = {24'h000000, mode_r}; // R13
                `AFC_OFF_OC_DAC: prdata_nxt = {24'h000000, dac_r}; // R7
                `AFC_OFF_OC_CAL: prdata_nxt = {24'h000000, cal_r}; // R13
                `AFC_OFF_PH1_CTRL: prdata_nxt = {24'h000000, ph1_r}; // R13
                `AFC_OFF_PH2_CTRL: prdata_nxt = {24'h000000, ph2_r}; // R13
                `AFC_OFF_PIN_FN: prdata_nxt = {24'h000000, pin_r};
                `AFC_OFF_IRQ_STAT: prdata_nxt = {31'h00000000, irq_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cmp_r <= `AFC_RST_CMP_CTRL; // R1 R2
            mode_r <= `AFC_RST_OC_MODE;
            dac_r <= `AFC_RST_OC_DAC; // R7
            cal_r <= `AFC_RST_OC_CAL; // R8 R9 R10
            ph1_r <= `AFC_RST_PH_CTRL; // R11
            ph2_r <= `AFC_RST_PH_CTRL; // R12
            pin_r <= `AFC_RST_PIN_FN;
            irq_r <= 1'b0;
            c0_d_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            cmp_r <= cmp_nxt;
            mode_r <= mode_nxt;
            dac_r <= dac_nxt;
            cal_r <= cal_nxt;
            ph1_r <= ph1_nxt;
            ph2_r <= ph2_nxt;
            pin_r <= pin_nxt;
            irq_r <= irq_nxt;
            c0_d_r <= c0_d_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // Static controls to the analog macros
    always_comb
    begin
        gain = mode_r[`AFC_GAIN_MSB:`AFC_GAIN_LSB];
        cmp_ctrl.hysteresis_en = cmp_r[`AFC_HYST_MSB:`AFC_HYST_LSB]; // R1 R17
        cmp_ctrl.on = cmp_r[`AFC_ON_MSB:`AFC_ON_LSB]; // R2 R17
        pullup_disconnect = cmp_r[`AFC_ON_MSB:`AFC_ON_LSB]; // R3
        dac_on = (edge_sel != AFC_EDGE_OFF); // R5
        cmp_zero_active = cmp_r[`AFC_ON_LSB] && (edge_sel != AFC_EDGE_OFF); // R5
        oc_amp.amp_en = (gain != 3'h0); // R6
        oc_amp.overcurrent_amp_gain = gain; // R6 R17
        oc_amp.offset_cal_on = cal_r[`AFC_CALON_BIT]; // R8
        oc_amp.cal_mode_sel = cal_r[`AFC_CALMODE_BIT]; // R9
        oc_amp.offset_trim = cal_r[`AFC_TRIM_MSB:`AFC_TRIM_LSB]; // R10
        phase_amp.phase_amp1_on = ph1_r[`AFC_PHON_BIT]; // R11
        phase_amp.phase_amp2_on = ph2_r[`AFC_PHON_BIT]; // R12
        common_negative_join = (pin_r[`AFC_PINFN_MSB:`AFC_PINFN_LSB] == `AFC_PINFN_JOIN); // R15
        overcurrent_cmp_irq = irq_r; // R14
        motor_shutdown_req = adc_limit_irq | irq_r; // R14
    end

    assign prdata = prdata_r;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_wr(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence

    sequence s_rd(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence

    // Comparator control
    a_hyst_reset: assert property ($rose(rst_n) |-> cmp_ctrl.hysteresis_en == 4'hF) // R1
        else $error("hysteresis enables not set after reset");
    a_cmp_on_reset: assert property ($rose(rst_n) |-> cmp_ctrl.on == 4'h0) // R2
        else $error("comparator enables not clear after reset");
    a_hyst_write: assert property (s_wr(`AFC_OFF_CMP_CTRL) |=> // R1
        cmp_ctrl.hysteresis_en == $past(pwdata[7:4]))
        else $error("hysteresis enables not updated after write");
    a_pullup_write: assert property (s_wr(`AFC_OFF_CMP_CTRL) |=> // R3
        pullup_disconnect == $past(pwdata[3:0]) && cmp_ctrl.on == pullup_disconnect)
        else $error("pull-high disconnect does not follow comparator enable");

    // Comparator 0 request
    a_edge_rise: assert property ((edge_sel == AFC_EDGE_RISE) && c0_sync && !c0_d_r // R5
        |=> overcurrent_cmp_irq)
        else $error("rising edge did not set request");
    a_edge_fall: assert property ((edge_sel == AFC_EDGE_FALL) && !c0_sync && c0_d_r // R5
        |=> overcurrent_cmp_irq)
        else $error("falling edge did not set request");
    a_edge_both: assert property ((edge_sel == AFC_EDGE_BOTH) && (c0_sync != c0_d_r) // R5
        |=> overcurrent_cmp_irq)
        else $error("edge did not set request in dual edge mode");
    a_dac_off: assert property ((edge_sel == AFC_EDGE_OFF) |-> !dac_on && !cmp_zero_active) // R5
        else $error("comparator 0 or DAC left on with edge field off");
    a_mode_reset: assert property ($rose(rst_n) |-> !dac_on && !oc_amp.amp_en) // R5
        else $error("DAC or amplifier on after reset");
    a_edge_none: assert property ((edge_sel == AFC_EDGE_OFF) && !overcurrent_cmp_irq // R16
        |=> !overcurrent_cmp_irq)
        else $error("request set with edge field off");
    a_sync_delay: assert property ($past(rst_n, 2) |-> c0_sync == $past(cmp_zero_out, 2)) // R16
        else $error("comparator 0 output not synchronised in two stages");
    a_irq_hold: assert property (overcurrent_cmp_irq && !irq_clr |=> overcurrent_cmp_irq) // R16
        else $error("request flag lost without clear");
    a_irq_clear: assert property (irq_clr && !edge_hit |=> !overcurrent_cmp_irq) // R16
        else $error("request flag not cleared");
    a_set_wins: assert property (edge_hit |=> overcurrent_cmp_irq) // R16
        else $error("detected edge did not set request");

    // Amplifier and DAC
    a_gain_update: assert property (s_wr(`AFC_OFF_OC_MODE) |=> // R6
        oc_amp.overcurrent_amp_gain == $past(pwdata[2:0])
        && oc_amp.amp_en == ($past(pwdata[2:0]) != 3'h0))
        else $error("gain field not updated after write");
    a_mode_read: assert property (s_rd(`AFC_OFF_OC_MODE) |-> // R13
        prdata[31:8] == 24'h000000 && prdata[5:3] == 3'h0)
        else $error("mode register unimplemented bits not zero");
    a_dac_follow: assert property ($past(rst_n) |-> dac_r == $past(dac_code)) // R7
        else $error("DAC register does not follow the DAC value");
    a_dac_read: assert property (s_rd(`AFC_OFF_OC_DAC) |-> // R7
        prdata == {24'h000000, $past(dac_r)})
        else $error("DAC read value wrong");
    a_cal_reset: assert property ($rose(rst_n) |-> !oc_amp.offset_cal_on && !oc_amp.cal_mode_sel) // R8
        else $error("calibration controls not clear after reset");
    a_cal_write: assert property (s_wr(`AFC_OFF_OC_CAL) |=> // R8
        oc_amp.offset_cal_on == $past(pwdata[6]) && oc_amp.cal_mode_sel == $past(pwdata[5])
        && oc_amp.offset_trim == $past(pwdata[4:0]))
        else $error("calibration fields not updated");
    a_trim_reset: assert property ($rose(rst_n) |-> oc_amp.offset_trim == 5'h10) // R10
        else $error("trim not at centre after reset");

    // Phase amplifiers, pin function and shutdown
    a_phase_reset: assert property ($rose(rst_n) |-> phase_amp == 2'h0) // R11
        else $error("phase amplifiers on after reset");
    a_ph1_write: assert property (s_wr(`AFC_OFF_PH1_CTRL) |=> // R11
        phase_amp.phase_amp1_on == $past(pwdata[7]))
        else $error("first phase amplifier enable not updated");
    a_ph2_write: assert property (s_wr(`AFC_OFF_PH2_CTRL) |=> // R12
        phase_amp.phase_amp2_on == $past(pwdata[7]))
        else $error("second phase amplifier enable not updated");
    a_phase_read: assert property (s_rd(`AFC_OFF_PH1_CTRL) |-> // R13
        prdata[6:0] == 7'h00 && prdata[7] == phase_amp.phase_amp1_on)
        else $error("phase control unimplemented bits not zero");
    a_ph2_read: assert property (s_rd(`AFC_OFF_PH2_CTRL) |-> // R12
        prdata[6:0] == 7'h00 && prdata[7] == phase_amp.phase_amp2_on)
        else $error("second phase control read wrong");
    a_join_pins: assert property (s_wr(`AFC_OFF_PIN_FN) |=> // R15
        common_negative_join == ($past(pwdata[1:0]) == `AFC_PINFN_JOIN))
        else $error("negative input join does not follow pin function");
    a_shutdown: assert property (adc_limit_irq |-> motor_shutdown_req) // R14
        else $error("limit request did not shut the drive");
endmodule

/* File: logic/afc_sync2.sv */
`timescale 1ns/1ns
module afc_sync2 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // First stage feeds only the second stage
    always_comb
    begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule

/* File: testbench/afc_analog_model.sv */
`timescale 1ns/1ns
module afc_analog_model (
    input wire logic clock,
    input wire logic cmp_level,
    input wire logic cmp_zero_active,
    input wire logic [7:0] dac_set,
    input wire logic limit_set,
    output logic cmp_zero_out,
    output logic [7:0] dac_code,
    output logic adc_limit_irq
);
    initial
    begin
        cmp_zero_out = 1'b0;
        dac_code = 8'h00;
        adc_limit_irq = 1'b0;
    end

    // Comparator 0 switched off drives its output low
    always @(posedge clock)
    begin
        cmp_zero_out <= cmp_zero_active & cmp_level;
        dac_code <= dac_set;
        adc_limit_irq <= limit_set;
    end
endmodule

/* File: testbench/afc_regs_tb_top.sv */
`timescale 1ns/1ns
module afc_regs_tb_top
    import afc_pkg::*;
;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, dac_code, dac_set, d8;
    logic [31:0] pwdata, prdata, rd;
    logic cmp_zero_out, adc_limit_irq, cmp_level, limit_set, flag_m;
    logic cmp_zero_active, dac_on, common_negative_join, overcurrent_cmp_irq, motor_shutdown_req;
    logic [3:0] pullup_disconnect;
    afc_cmp_ctrl_t cmp_ctrl;
    afc_oc_amp_t oc_amp;
    afc_phase_amp_t phase_amp;
    int mismatches = 0;
    int n_tests = 0;
    int i, k, m, lv;
    logic [7:0] lfsr = 8'h3A;
    logic [7:0] mdl [8];
    logic [7:0] dac_m;
    logic [7:0] msk [7] = '{8'hFF, 8'hC7, 8'h00, 8'h7F, 8'h80, 8'h80, 8'h03};

    afc_regs i_afc_regs (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_zero_out(cmp_zero_out), .dac_code(dac_code),
        .adc_limit_irq(adc_limit_irq), .cmp_ctrl(cmp_ctrl),
        .pullup_disconnect(pullup_disconnect), .cmp_zero_active(cmp_zero_active),
        .dac_on(dac_on), .oc_amp(oc_amp), .phase_amp(phase_amp),
        .common_negative_join(common_negative_join),
        .overcurrent_cmp_irq(overcurrent_cmp_irq), .motor_shutdown_req(motor_shutdown_req));

    afc_analog_model i_afc_analog_model (.clock(clock), .cmp_level(cmp_level),
        .cmp_zero_active(cmp_zero_active), .dac_set(dac_set), .limit_set(limit_set),
        .cmp_zero_out(cmp_zero_out), .dac_code(dac_code), .adc_limit_irq(adc_limit_irq));

    function logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task stop_test;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task chk_outs;
        logic [1:0] e;
        logic [2:0] g;
        e = mdl[1][7:6];
        g = mdl[1][2:0];
        chk("cmp_ctrl", cmp_ctrl, mdl[0]);
        chk("pullup", pullup_disconnect, mdl[0][3:0]);
        chk("dac_on", dac_on, e != 2'h0);
        chk("cmp0_active", cmp_zero_active, mdl[0][0] && e != 2'h0);
        chk("oc_amp", oc_amp, {g != 3'h0, g, mdl[3][6:0]});
        chk("phase", phase_amp, {mdl[4][7], mdl[5][7]});
        chk("join", common_negative_join, mdl[6][1:0] == 2'h2);
        chk("irq", overcurrent_cmp_irq, flag_m);
        chk("shutdown", motor_shutdown_req, flag_m | limit_set);
    endtask

    task wr(input int idx, input logic [31:0] d);
        apb(1'b1, 8'(idx * 4), d);
        if (idx < 7)
            mdl[idx] = d[7:0] & msk[idx];
        else if (d[0])
            flag_m = 1'b0;
        #1;
        chk_outs;
    endtask

    task rdchk(input int idx);
        apb(1'b0, 8'(idx * 4), 32'h0000_0000);
        chk("read", rd, idx == 2 ? dac_m : (idx == 7 ? {7'h00, flag_m} : mdl[idx]));
        chk("err", err, 1'b0);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        stop_test;
    end

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        cmp_level = 1'b0;
        limit_set = 1'b0;
        dac_set = 8'h00;
        dac_m = 8'h00;
        flag_m = 1'b0;
        mdl = '{8'hF0, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk_outs;
        for (i = 0; i < 8; i++)
            rdchk(i);
        d8 = rnd();
        @(posedge clock);
        dac_set <= d8;
        dac_m = d8;
        wr(2, 32'hFFFF_FFFF);
        rdchk(2);
        for (i = 0; i < 24; i++)
        begin
            k = rnd() % 7;
            wr(k, {rnd(), rnd(), rnd(), rnd()});
            rdchk(k);
        end
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        chk("slverr", err, 1'b1);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        chk("slverr", err, 1'b1);
        for (i = 0; i < 8; i++)
            rdchk(i);
        wr(0, 32'h0000_0001);
        wr(7, 32'h0000_0001);
        for (m = 0; m < 4; m++)
        begin
            wr(1, {24'h000000, m[1:0], 6'h00});
            for (lv = 1; lv >= 0; lv--)
            begin
                @(posedge clock);
                cmp_level <= lv[0];
                repeat (5) @(posedge clock);
                #1;
                if ((lv == 1 && m[0]) || (lv == 0 && m[1]))
                    flag_m = 1'b1;
                chk_outs;
                wr(7, 32'h0000_0000);
                rdchk(7);
                wr(7, 32'h0000_0001);
            end
        end
        wr(1, 32'h0000_0080);
        @(posedge clock);
        cmp_level <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
        chk_outs;
        wr(1, 32'h0000_0000);
        repeat (5) @(posedge clock);
        #1;
        chk_outs;
        @(posedge clock);
        limit_set <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk_outs;
        @(posedge clock);
        limit_set <= 1'b0;
        wr(0, 32'h0000_00F0);
        stop_test;
    end
endmodule
